// File: design/com_mode_fsm.sv
/*
 * operating-mode controller: run, halt, error, hold and forced run.
 * assumes tool commands, fault and io-absent flags come from logic on mclk;
 * the mode switch and input pins are asynchronous.
 */
// What this block does
// R1: run mode samples inputs, executes program, drives outputs from results.
// R2: program edits and non-volatile writes accepted in run mode.
// R3: halt mode stops execution and forces all outputs off.
// R4: full program download accepted only in halt, rejected otherwise.
// R5: self-diagnosis fault enters error from any mode, outputs off.
// R6: error is left only by error-reset command or power cycle.
// R7: shutdown cause stays readable while in error.
// R8: hold stops execution but keeps i/o updating, outputs held.
// R9: in hold the tool may write data that appears on outputs.
// R10: forced run executes like run but ignores absent expansion modules.
// R11: mode follows mode switch position combined with tool commands.
// R12: switch resting at halt selects halt, at run selects run.
// R13: switch turned to halt or halt command moves to halt.
// R14: switch turned to run or run command moves to run; in hold mode the run command is ignored.
// R15: forced-run command enters forced-run mode.
// R16: hold command enters hold mode.
// R17: hold-cancel command leaves hold mode.
// R18: tool mode commands honoured only with switch at run side.
// R19: reload from non-volatile storage only in halt mode.
// R20: hold-cancel returns to run mode.
// R21: error reset leaves error into halt with outputs off.
// R22: hold only from run, forced run only from run or halt; error takes only reset.
`timescale 1ns/100ps
module com_mode_fsm #(
   parameter int IN_W    = com_pkg::IN_W,
   parameter int OUT_W   = com_pkg::OUT_W,
   parameter int CAUSE_W = com_pkg::CAUSE_W
) (
   input  wire logic                   mclk,
   input  wire logic                   rst_n,
   input  wire logic                   modeSwitchRun,
   input  wire logic [IN_W-1:0]        inPins,
   input  wire com_pkg::com_mode_cmd_t modeCmd,
   input  wire com_pkg::com_prog_req_t progReq,
   input  wire logic                   diagFault,
   input  wire logic [CAUSE_W-1:0]     faultCause,
   input  wire logic                   ioAbsent,
   input  wire logic [OUT_W-1:0]       progResult,
   input  wire logic [OUT_W-1:0]       forceData,
   input  wire logic                   forceWrite,
   output com_pkg::com_mode_t          mode,
   output com_pkg::com_gate_t          gate,
   output logic [IN_W-1:0]             inImage,
   output logic [OUT_W-1:0]            outPins,
   output logic [CAUSE_W-1:0]          errorCause,
   output com_pkg::com_prog_req_t      progGrant,
   output com_pkg::com_prog_req_t      progReject
);

   logic                   switchRunSync;
   logic [IN_W-1:0]        inSync;

   com_pkg::com_mode_t     mode_reg;
   com_pkg::com_mode_t     mode_next;
   logic                   initDone_reg;
   logic                   initDone_next;
   logic                   switchPrev_reg;
   logic                   switchPrev_next;
   logic [CAUSE_W-1:0]     cause_reg;
   logic [CAUSE_W-1:0]     cause_next;
   com_pkg::com_gate_t     gate_reg;
   com_pkg::com_gate_t     gate_next;
   logic [IN_W-1:0]        inImage_reg;
   logic [IN_W-1:0]        inImage_next;
   com_pkg::com_prog_req_t grant_reg;
   com_pkg::com_prog_req_t grant_next;
   com_pkg::com_prog_req_t reject_reg;
   com_pkg::com_prog_req_t reject_next;

   logic cmdOk;
   logic switchToHalt;
   logic switchToRun;

   com_sync #(
      .W (1)
   ) u_switch_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .asyncIn (modeSwitchRun),
      .syncOut (switchRunSync)
   );

   com_sync #(
      .W (IN_W)
   ) u_pin_sync (
      .mclk    (mclk),
      .rst_n   (rst_n),
      .asyncIn (inPins),
      .syncOut (inSync)
   );

   com_out_stage #(
      .W (OUT_W)
   ) u_out_stage (
      .mclk       (mclk),
      .rst_n      (rst_n),
      .gate       (gate_reg),
      .progResult (progResult),
      .forceData  (forceData),
      .forceWrite (forceWrite && switchRunSync),
      .outPins    (outPins)
   );

   // switch events and command window
   assign cmdOk        = switchRunSync;                              // [R18]
   assign switchToHalt = initDone_reg && switchPrev_reg && !switchRunSync;
   assign switchToRun  = initDone_reg && !switchPrev_reg && switchRunSync;

   // mode selection
   always_comb begin
      mode_next       = mode_reg;
      initDone_next   = 1'b1;
      switchPrev_next = switchRunSync;
      cause_next      = cause_reg;
      if (diagFault) begin
         mode_next  = com_pkg::MODE_ERROR;                           // [R5]
         if (mode_reg != com_pkg::MODE_ERROR) begin
            cause_next = faultCause;                                 // [R7]
         end
      end else if (!initDone_reg) begin
         mode_next = switchRunSync ? com_pkg::MODE_RUN : com_pkg::MODE_HALT; // [R12]
      end else begin
         case (mode_reg)
            com_pkg::MODE_ERROR: begin
               if (cmdOk && modeCmd.errorReset) begin
                  mode_next  = com_pkg::MODE_HALT;                   // [R6] [R21] [R22]
                  cause_next = com_pkg::CAUSE_NONE;
               end
            end
            com_pkg::MODE_HALT: begin
               if (switchToRun || (cmdOk && modeCmd.run)) begin
                  mode_next = com_pkg::MODE_RUN;                     // [R11] [R14]
               end else if (cmdOk && modeCmd.runForced) begin
                  mode_next = com_pkg::MODE_RUNF;                    // [R15] [R22]
               end
            end
            com_pkg::MODE_RUN: begin
               if (switchToHalt || (cmdOk && modeCmd.halt)) begin
                  mode_next = com_pkg::MODE_HALT;                    // [R13]
               end else if (cmdOk && modeCmd.hold) begin
                  mode_next = com_pkg::MODE_HOLD;                    // [R16] [R22]
               end else if (cmdOk && modeCmd.runForced) begin
                  mode_next = com_pkg::MODE_RUNF;                    // [R15]
               end else if (ioAbsent) begin
                  mode_next  = com_pkg::MODE_ERROR;
                  cause_next = com_pkg::CAUSE_IO_ABSENT;
               end
            end
            com_pkg::MODE_RUNF: begin
               if (switchToHalt || (cmdOk && modeCmd.halt)) begin
                  mode_next = com_pkg::MODE_HALT;                    // [R13]
               end else if (cmdOk && modeCmd.run) begin
                  mode_next = com_pkg::MODE_RUN;                     // [R14]
               end
            end
            com_pkg::MODE_HOLD: begin
               if (switchToHalt || (cmdOk && modeCmd.halt)) begin
                  mode_next = com_pkg::MODE_HALT;                    // [R13]
               end else if (cmdOk && modeCmd.holdCancel) begin
                  mode_next = com_pkg::MODE_RUN;                     // [R17] [R20]
               end
            end
            default: begin
               mode_next = com_pkg::MODE_HALT;
            end
         endcase
      end
   end

   // gating follows the next mode so it lines up with mode_reg
   always_comb begin
      gate_next = '0;
      case (mode_next)
         com_pkg::MODE_RUN,
         com_pkg::MODE_RUNF: begin
            gate_next.execEnable = 1'b1;                             // [R1] [R10]
            gate_next.ioUpdate   = 1'b1;
         end
         com_pkg::MODE_HOLD: begin
            gate_next.ioUpdate  = 1'b1;                              // [R8]
            gate_next.holdForce = 1'b1;                              // [R9]
         end
         com_pkg::MODE_HALT,
         com_pkg::MODE_ERROR: begin
            gate_next.outputsOff = 1'b1;                             // [R3] [R5] [R21]
         end
         default: begin
            gate_next.outputsOff = 1'b1;
         end
      endcase
   end

   // input image refresh
   always_comb begin
      inImage_next = inImage_reg;
      if (gate_reg.ioUpdate) begin
         inImage_next = inSync;                                      // [R1] [R8]
      end
   end

   // program maintenance grants
   always_comb begin
      grant_next  = '0;
      reject_next = '0;
      if (mode_reg == com_pkg::MODE_HALT) begin
         grant_next.download = progReq.download;                     // [R4]
         grant_next.reload   = progReq.reload;                       // [R19]
      end else begin
         reject_next.download = progReq.download;                    // [R4]
         reject_next.reload   = progReq.reload;                      // [R19]
      end
      if (mode_reg == com_pkg::MODE_HALT || mode_reg == com_pkg::MODE_RUN ||
          mode_reg == com_pkg::MODE_RUNF) begin
         grant_next.nvWrite  = progReq.nvWrite;                      // [R2]
         grant_next.progEdit = progReq.progEdit;                     // [R2]
      end else begin
         reject_next.nvWrite  = progReq.nvWrite;
         reject_next.progEdit = progReq.progEdit;
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg       <= com_pkg::MODE_HALT;
         initDone_reg   <= com_pkg::RST_INIT_DONE;
         switchPrev_reg <= com_pkg::RST_SWITCH;
         cause_reg      <= com_pkg::CAUSE_NONE;
         gate_reg       <= com_pkg::RST_GATE;
         inImage_reg    <= '0;
         grant_reg      <= '0;
         reject_reg     <= '0;
      end else begin
         mode_reg       <= mode_next;
         initDone_reg   <= initDone_next;
         switchPrev_reg <= switchPrev_next;
         cause_reg      <= cause_next;
         gate_reg       <= gate_next;
         inImage_reg    <= inImage_next;
         grant_reg      <= grant_next;
         reject_reg     <= reject_next;
      end
   end

   assign mode       = mode_reg;
   assign gate       = gate_reg;
   assign inImage    = inImage_reg;
   assign errorCause = cause_reg;
   assign progGrant  = grant_reg;
   assign progReject = reject_reg;

   // checks
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!rst_n);

   a_fault_enters_error: assert property ( // [R5]
      diagFault |=> mode_reg == com_pkg::MODE_ERROR ##1 outPins == '0)
      else $error("fault did not shut down");

   a_error_only_reset: assert property ( // [R6]
      mode_reg == com_pkg::MODE_ERROR && !(switchRunSync && modeCmd.errorReset)
      |=> mode_reg == com_pkg::MODE_ERROR)
      else $error("error left without reset");

   a_error_reset_halt: assert property ( // [R21]
      mode_reg == com_pkg::MODE_ERROR && !diagFault && switchRunSync && modeCmd.errorReset
      |=> mode_reg == com_pkg::MODE_HALT && gate_reg.outputsOff)
      else $error("error reset did not reach halt");

   a_cause_kept: assert property ( // [R7]
      mode_reg == com_pkg::MODE_ERROR && $past(mode_reg) == com_pkg::MODE_ERROR
      |-> $stable(cause_reg))
      else $error("cause changed in error");

   a_halt_outputs_off: assert property ( // [R3]
      mode_reg == com_pkg::MODE_HALT ##1 mode_reg == com_pkg::MODE_HALT
      |-> outPins == '0 && !gate_reg.execEnable)
      else $error("halt outputs not off");

   a_download_halt_only: assert property ( // [R4]
      progReq.download |=> (progGrant.download == ($past(mode_reg) == com_pkg::MODE_HALT))
      && (progReject.download != progGrant.download))
      else $error("download gating wrong");

   a_cmd_ignored_halt_side: assert property ( // [R18]
      initDone_reg && mode_reg == com_pkg::MODE_HALT && !switchRunSync && !diagFault
      |=> mode_reg == com_pkg::MODE_HALT)
      else $error("command honoured at halt side");

   a_hold_cancel_run: assert property ( // [R20]
      mode_reg == com_pkg::MODE_HOLD && switchRunSync && modeCmd.holdCancel
      && !modeCmd.halt && !diagFault |=> mode_reg == com_pkg::MODE_RUN)
      else $error("hold cancel did not run");

   a_hold_keeps_io: assert property ( // [R8]
      mode_reg == com_pkg::MODE_HOLD |-> gate_reg.ioUpdate && !gate_reg.execEnable)
      else $error("hold gating wrong");

   a_runf_no_io_stop: assert property ( // [R10]
      mode_reg == com_pkg::MODE_RUNF && ioAbsent && !diagFault
      |=> mode_reg != com_pkg::MODE_ERROR)
      else $error("forced run stopped on absent io");

   a_switch_to_halt: assert property ( // [R13]
      switchToHalt && !diagFault && mode_reg != com_pkg::MODE_ERROR
      |=> mode_reg == com_pkg::MODE_HALT)
      else $error("switch to halt ignored");

endmodule

// File: design/com_pkg.sv
/*
 * shared types and constants of the controller operating-mode block.
 * assumes a single clock domain; tool requests arrive as one-cycle pulses.
 */
package com_pkg;

   // default widths of the i/o image and the shutdown cause
   localparam int IN_W    = 8;
   localparam int OUT_W   = 8;
   localparam int CAUSE_W = 8;

   // shutdown cause values
   localparam logic [CAUSE_W-1:0] CAUSE_NONE      = 8'h00;
   localparam logic [CAUSE_W-1:0] CAUSE_IO_ABSENT = 8'h01;

   // reset values
   localparam logic RST_INIT_DONE = 1'b0;
   localparam logic RST_SWITCH    = 1'b0;

   // synchroniser depth for pin inputs
   localparam int SYNC_STAGES = 2;

   typedef enum logic [2:0] {
      MODE_HALT,
      MODE_RUN,
      MODE_RUNF,
      MODE_HOLD,
      MODE_ERROR
   } com_mode_t;

   // mode commands from the programming tool, one-cycle pulses
   typedef struct packed {
      logic run;
      logic halt;
      logic runForced;
      logic hold;
      logic holdCancel;
      logic errorReset;
   } com_mode_cmd_t;

   // program maintenance requests, and their grant or reject pulses
   typedef struct packed {
      logic download;
      logic reload;
      logic nvWrite;
      logic progEdit;
   } com_prog_req_t;

   // gating towards the scan engine and the output stage
   typedef struct packed {
      logic execEnable;
      logic ioUpdate;
      logic outputsOff;
      logic holdForce;
   } com_gate_t;

   // gating reset value: outputs off only
   localparam com_gate_t RST_GATE = 4'h2;

endpackage

// File: design/com_sync.sv
/*
 * multi-bit two-flop synchroniser for pin inputs.
 * assumes each bit is an independent level; no bus coherence is given.
 */
`timescale 1ns/100ps
module com_sync #(
   parameter int W = 1
) (
   input  wire logic         mclk,
   input  wire logic         rst_n,
   input  wire logic [W-1:0] asyncIn,
   output logic      [W-1:0] syncOut
);

   logic [W-1:0] meta_reg;
   logic [W-1:0] sync_reg;

   // first stage feeds only the second
   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         meta_reg <= '0;
         sync_reg <= '0;
      end else begin
         meta_reg <= asyncIn;
         sync_reg <= meta_reg;
      end
   end

   assign syncOut = sync_reg;

endmodule

// File: design/com_out_stage.sv
/*
 * output image register driven by the mode gating.
 * assumes gate, result and force data come from logic on mclk.
 */
`timescale 1ns/100ps
module com_out_stage #(
   parameter int W = 8
) (
   input  wire logic              mclk,
   input  wire logic              rst_n,
   input  wire com_pkg::com_gate_t gate,
   input  wire logic [W-1:0]      progResult,
   input  wire logic [W-1:0]      forceData,
   input  wire logic              forceWrite,
   output logic      [W-1:0]      outPins
);

   logic [W-1:0] out_reg;
   logic [W-1:0] out_next;

   always_comb begin
      out_next = out_reg;
      if (gate.outputsOff) begin
         out_next = '0;                              // [R3] [R5]
      end else if (gate.execEnable) begin
         out_next = progResult;                      // [R1] [R10]
      end else if (gate.holdForce && forceWrite) begin
         out_next = forceData;                       // [R9]
      end
   end

   always_ff @(posedge mclk or negedge rst_n) begin
      if (!rst_n) begin
         out_reg <= '0;
      end else begin
         out_reg <= out_next;
      end
   end

   assign outPins = out_reg;

endmodule

// File: dv/com_tool_model.sv
/*
 * programming tool and front-panel switch model: mode commands, program requests,
 * output force writes and switch level.
 * assumes the bench calls its tasks just after a rising edge of mclk.
 */
`timescale 1ns/100ps
module com_tool_model (
   input  wire logic                   mclk,
   output com_pkg::com_mode_cmd_t      modeCmd,
   output com_pkg::com_prog_req_t      progReq,
   output logic                        modeSwitchRun,
   output logic [com_pkg::OUT_W-1:0]   forceData,
   output logic                        forceWrite
);
   initial begin
      modeCmd = '0;
      progReq = '0;
      modeSwitchRun = 1'b1;
      forceData = '0;
      forceWrite = 1'b0;
   end
   // one-cycle command pulse
   task automatic cmd(input com_pkg::com_mode_cmd_t c);
      @(posedge mclk); #1;
      modeCmd = c;
      @(posedge mclk); #1;
      modeCmd = '0;
   endtask
   task automatic req(input com_pkg::com_prog_req_t r);
      @(posedge mclk); #1;
      progReq = r;
      @(posedge mclk); #1;
      progReq = '0;
   endtask
   // data stands only while the strobe is high
   task automatic force_out(input logic [com_pkg::OUT_W-1:0] d);
      @(posedge mclk); #1;
      forceData = d;
      forceWrite = 1'b1;
      @(posedge mclk); #1;
      forceWrite = 1'b0;
      forceData = ~d;
   endtask
   task automatic set_switch(input logic v);
      @(posedge mclk); #1;
      modeSwitchRun = v;
   endtask
endmodule

// File: dv/controller_operation_mode_fsm_bench.sv
/*
 * self-checking bench of the operating-mode controller.
 * assumes the tool model drives commands and switch; bench drives pins and faults.
 */
`timescale 1ns/100ps
`define CHK(g, e) begin checks_done++; if ((g) !== (e)) begin num_errors++; \
   $display("[ERR] %0t got %0h exp %0h", $time, g, e); end end
module controller_operation_mode_fsm_bench;
   localparam com_pkg::com_mode_cmd_t C_RUN  = 6'h20;
   localparam com_pkg::com_mode_cmd_t C_HALT = 6'h10;
   localparam com_pkg::com_mode_cmd_t C_RUNF = 6'h08;
   localparam com_pkg::com_mode_cmd_t C_HOLD = 6'h04;
   localparam com_pkg::com_mode_cmd_t C_HCAN = 6'h02;
   localparam com_pkg::com_mode_cmd_t C_ERST = 6'h01;
   localparam com_pkg::com_prog_req_t Q_DL   = 4'h8;
   localparam com_pkg::com_prog_req_t Q_RL   = 4'h4;
   localparam com_pkg::com_prog_req_t Q_NV   = 4'h2;
   localparam com_pkg::com_prog_req_t Q_ED   = 4'h1;
   logic                        mclk, rst_n, diagFault, ioAbsent, modeSwitchRun, forceWrite;
   logic [com_pkg::IN_W-1:0]    inPins, inImage;
   logic [com_pkg::OUT_W-1:0]   progResult, forceData, outPins;
   logic [com_pkg::CAUSE_W-1:0] faultCause, errorCause;
   com_pkg::com_mode_cmd_t      modeCmd;
   com_pkg::com_prog_req_t      progReq, progGrant, progReject;
   com_pkg::com_mode_t          mode;
   com_pkg::com_gate_t          gate;
   int                          num_errors = 0;
   int                          checks_done = 0;

   com_mode_fsm i_dut (.mclk(mclk), .rst_n(rst_n), .modeSwitchRun(modeSwitchRun),
      .inPins(inPins), .modeCmd(modeCmd), .progReq(progReq), .diagFault(diagFault),
      .faultCause(faultCause), .ioAbsent(ioAbsent), .progResult(progResult),
      .forceData(forceData), .forceWrite(forceWrite), .mode(mode), .gate(gate),
      .inImage(inImage), .outPins(outPins), .errorCause(errorCause),
      .progGrant(progGrant), .progReject(progReject));
   com_tool_model i_tool (.mclk(mclk), .modeCmd(modeCmd), .progReq(progReq),
      .modeSwitchRun(modeSwitchRun), .forceData(forceData), .forceWrite(forceWrite));

   initial begin
      mclk = 1'b0;
      forever #4 mclk = ~mclk;
   end

   task automatic cyc(input int n);
      repeat (n) @(posedge mclk);
      #1;
   endtask
   task automatic wait_mode(input com_pkg::com_mode_t m);
      for (int i = 0; i < 8 && mode !== m; i++) cyc(1);
      `CHK(mode, m)
   endtask
   task automatic final_report();
      if (num_errors == 0 && checks_done > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic t_run();
      `CHK(mode, com_pkg::MODE_RUN)
      `CHK(gate.execEnable, 1'b1)
      inPins = 8'h3C;
      progResult = 8'hA5;
      cyc(4);
      `CHK(inImage, 8'h3C)
      `CHK(outPins, 8'hA5)
      i_tool.req(Q_NV);
      `CHK(progGrant.nvWrite, 1'b1)
      i_tool.req(Q_ED);
      `CHK(progGrant.progEdit, 1'b1)
      i_tool.req(Q_DL);
      `CHK(progReject.download, 1'b1)
      i_tool.req(Q_RL);
      `CHK(progReject.reload, 1'b1)
   endtask
   task automatic t_hold();
      i_tool.cmd(C_HOLD);
      `CHK(mode, com_pkg::MODE_HOLD)
      `CHK(gate.execEnable, 1'b0)
      `CHK(gate.ioUpdate, 1'b1)
      `CHK(gate.holdForce, 1'b1)
      progResult = 8'h11;
      cyc(3);
      `CHK(outPins, 8'hA5)
      i_tool.force_out(8'h5A);
      cyc(1);
      `CHK(outPins, 8'h5A)
      i_tool.cmd(C_RUNF);
      `CHK(mode, com_pkg::MODE_HOLD)
      i_tool.cmd(C_HCAN);
      `CHK(mode, com_pkg::MODE_RUN)
   endtask
   task automatic t_halt();
      i_tool.cmd(C_HALT);
      `CHK(mode, com_pkg::MODE_HALT)
      `CHK(gate.execEnable, 1'b0)
      `CHK(gate.outputsOff, 1'b1)
      cyc(1);
      `CHK(outPins, 8'h00)
      i_tool.req(Q_DL);
      `CHK(progGrant.download, 1'b1)
      i_tool.req(Q_RL);
      `CHK(progGrant.reload, 1'b1)
      i_tool.cmd(C_RUNF);
      `CHK(mode, com_pkg::MODE_RUNF)
      ioAbsent = 1'b1;
      cyc(3);
      `CHK(mode, com_pkg::MODE_RUNF)
      `CHK(gate.execEnable, 1'b1)
      i_tool.cmd(C_RUN);
      wait_mode(com_pkg::MODE_ERROR);
      `CHK(errorCause, com_pkg::CAUSE_IO_ABSENT)
      ioAbsent = 1'b0;
      i_tool.cmd(C_ERST);
      `CHK(mode, com_pkg::MODE_HALT)
      `CHK(gate.outputsOff, 1'b1)
      i_tool.cmd(C_RUN);
      `CHK(mode, com_pkg::MODE_RUN)
   endtask
   task automatic t_switch();
      i_tool.set_switch(1'b0);
      wait_mode(com_pkg::MODE_HALT);
      i_tool.cmd(C_RUN);
      `CHK(mode, com_pkg::MODE_HALT)
      i_tool.cmd(C_RUNF);
      `CHK(mode, com_pkg::MODE_HALT)
      i_tool.set_switch(1'b1);
      wait_mode(com_pkg::MODE_RUN);
   endtask
   task automatic t_error();
      faultCause = 8'h7E;
      diagFault = 1'b1;
      cyc(1);
      diagFault = 1'b0;
      faultCause = 8'h81;
      `CHK(mode, com_pkg::MODE_ERROR)
      `CHK(gate.execEnable, 1'b0)
      cyc(1);
      `CHK(outPins, 8'h00)
      `CHK(errorCause, 8'h7E)
      i_tool.cmd(C_RUN);
      `CHK(mode, com_pkg::MODE_ERROR)
      i_tool.cmd(C_HOLD);
      `CHK(mode, com_pkg::MODE_ERROR)
      i_tool.set_switch(1'b0);
      cyc(4);
      i_tool.set_switch(1'b1);
      cyc(4);
      `CHK(mode, com_pkg::MODE_ERROR)
      `CHK(errorCause, 8'h7E)
      i_tool.cmd(C_ERST);
      `CHK(mode, com_pkg::MODE_HALT)
      `CHK(errorCause, com_pkg::CAUSE_NONE)
   endtask

   initial begin
      rst_n = 1'b0;
      diagFault = 1'b0;
      ioAbsent = 1'b0;
      inPins = '0;
      progResult = '0;
      faultCause = '0;
      repeat (4) @(posedge mclk);
      #1;
      rst_n = 1'b1;
      cyc(3);
      t_run();
      t_hold();
      t_halt();
      t_switch();
      t_error();
      final_report();
   end

   initial begin
      #40000;
      num_errors++;
      final_report();
   end
endmodule
